// ===== wcmp_cfg.svh
// wcmp_cfg.svh: constants of the analog window comparator
// assumes inclusion by the package and by each design file
`ifndef WCMP_CFG_SVH
`define WCMP_CFG_SVH

// full scale in permille, and the 4 mA point of a 0..20 mA reading
`define WCMP_FS 10'h3E8
`define WCMP_I4MA 10'h0C8
`define WCMP_PCT_MAX 7'h64
`define WCMP_HYS_MAX 4'hA

// terminal function codes
`define WCMP_FN_OPEN1 8'h1B
`define WCMP_FN_OPEN2 8'h1C
`define WCMP_FN_WIN1 8'h36
`define WCMP_FN_WIN2 8'h37

// register byte addresses
`define WCMP_A_CTRL 8'h00
`define WCMP_A_CFG1 8'h04
`define WCMP_A_CFG2 8'h08
`define WCMP_A_TERM 8'h0C
`define WCMP_A_STAT 8'h10
`define WCMP_A_ISTS 8'h14
`define WCMP_A_IMSK 8'h18
`define WCMP_A_VAL 8'h1C

// writable bits and reset values
`define WCMP_CFG_MASK 32'hFF0F_7F7F
`define WCMP_CFG_RST 32'h0000_0064
`define WCMP_TERM_MASK 32'h00FF_FFFF
`define WCMP_TERM_RST 32'h0000_0000
`define WCMP_CTRL_RST 2'h0
`define WCMP_IRQ_RST 4'h0

// interrupt event bits
`define WCMP_EV_RISE1 0
`define WCMP_EV_RISE2 1
`define WCMP_EV_FALL1 2
`define WCMP_EV_FALL2 3

// terminal index
`define WCMP_T_A 0
`define WCMP_T_B 1
`define WCMP_T_C 2

`endif

// ===== wcmp_pkg.sv
// wcmp_pkg.sv: types and shared arithmetic of the window comparator
// assumes wcmp_cfg.svh is on the include path
`default_nettype none
`include "wcmp_cfg.svh"

package wcmp_pkg;

	// permille of the input span
	typedef logic [9:0] wcmp_pm_t;

	typedef struct packed {
		logic sub_en;
		logic [6:0] substitute_level;
		logic [3:0] rsv2;
		logic [3:0] hysteresis;
		logic rsv1;
		logic [6:0] lower_limit;
		logic rsv0;
		logic [6:0] upper_limit;
	} wcmp_cfg_s;

	typedef struct packed {
		logic [7:0] rsv;
		logic [7:0] output_terminal_c_select;
		logic [7:0] output_terminal_b_select;
		logic [7:0] output_terminal_a_select;
	} wcmp_term_s;

	function automatic wcmp_pm_t pct2pm(input logic [6:0] p);
		pct2pm = 10'({p, 3'h0}) + 10'({p, 1'h0});
	endfunction

	// voltage spans 0..10 V, current 4..20 mA of a 0..20 mA reading
	function automatic wcmp_pm_t norm(input logic [9:0] raw, input logic cur);
		logic [9:0] d;
		logic [10:0] s;
		d = raw - `WCMP_I4MA;
		s = {1'b0, d} + {3'h0, d[9:2]};
		if (!cur)
			norm = (raw > `WCMP_FS) ? `WCMP_FS : raw;
		else if (raw < `WCMP_I4MA)
			norm = 10'h000;
		else
			norm = (s > {1'b0, `WCMP_FS}) ? `WCMP_FS : s[9:0];
	endfunction

	function automatic logic cfg_ok(input wcmp_cfg_s c);
		logic [7:0] need;
		need = {1'b0, c.lower_limit} + {3'h0, c.hysteresis, 1'b0};
		cfg_ok = (c.upper_limit <= `WCMP_PCT_MAX) && (c.hysteresis <= `WCMP_HYS_MAX)
			&& (c.substitute_level <= `WCMP_PCT_MAX) && ({1'b0, c.upper_limit} >= need);
	endfunction

endpackage

`default_nettype wire

// ===== wcmp_chan.sv
// wcmp_chan.sv: one input's window comparator and value selection
// assumes samples synchronous to i_clk, one strobe per new sample
`default_nettype none
`include "wcmp_cfg.svh"

module wcmp_chan (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// sample and control
	input wire logic i_smp_vld,
	input wire logic [9:0] i_raw,
	input wire logic i_cur,
	input wire logic i_hold,
	input wire wcmp_pkg::wcmp_cfg_s i_cfg,
	// results
	output logic o_flag,
	output wcmp_pkg::wcmp_pm_t o_value
);
	import wcmp_pkg::*;

	wcmp_pm_t meas, up, lo, hy, sub, held, next_value;
	logic [10:0] lo_hy, v_hy, up_hy;
	logic set_in, clr_out, next_flag;

	// no frequency start/end scaling enters the comparison
	assign meas = norm(i_raw, i_cur); // R12 R11
	assign up = pct2pm(i_cfg.upper_limit);
	assign lo = pct2pm(i_cfg.lower_limit);
	assign hy = pct2pm({3'h0, i_cfg.hysteresis}); // R3
	assign sub = pct2pm(i_cfg.substitute_level);
	assign lo_hy = {1'b0, lo} + {1'b0, hy};
	assign v_hy = {1'b0, meas} + {1'b0, hy};
	assign up_hy = {1'b0, up} + {1'b0, hy};
	// a limit at the span end needs no margin, else open/short never trips
	assign set_in = (lo == 10'h000 || {1'b0, meas} >= lo_hy)
		&& (up == `WCMP_FS || v_hy <= {1'b0, up}); // R2 R17 R15 R16
	assign clr_out = (v_hy < {1'b0, lo}) || ({1'b0, meas} > up_hy); // R17
	assign next_flag = o_flag ? !clr_out : set_in; // R2
	assign next_value = i_hold ? held : // R10
		(next_flag && i_cfg.sub_en) ? sub : meas; // R8 R9

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_flag <= 1'b0;
			o_value <= 10'h000;
			held <= 10'h000;
		end else if (i_smp_vld) begin // R18
			o_flag <= next_flag;
			o_value <= next_value;
			if (!i_hold)
				held <= meas;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	upd_on_smp_a: assert property ( // R18
		!i_smp_vld |=> $stable(o_flag) && $stable(o_value)) else $error("changed without sample");
	win_set_a: assert property ( // R2
		i_smp_vld && !o_flag && set_in |=> o_flag) else $error("flag not raised in band");
	flag_keep_a: assert property ( // R17
		i_smp_vld && o_flag && !clr_out |=> o_flag) else $error("flag dropped inside margin");
	subst_a: assert property ( // R8
		i_smp_vld && !i_hold && i_cfg.sub_en && next_flag |=> o_value == $past(sub))
		else $error("substitute not used");
	pass_thru_a: assert property ( // R9
		i_smp_vld && !i_hold && !i_cfg.sub_en |=> o_value == $past(meas))
		else $error("measured value not passed");
	hold_pri_a: assert property ( // R10
		i_smp_vld && i_hold |=> o_value == $past(held)) else $error("held value lost priority");

endmodule

`default_nettype wire

// ===== wcmp_top.sv
// wcmp_top.sv: two-input analog window comparator with APB registers
// assumes an APB master on I_CLK and samples synchronous to I_CLK
// Overview of operation
// R1 - each of three terminals selects open or window flag by code
// R2 - flag is set while the input lies inside its limit band
// R3 - hysteresis of 0 to 10 percent widens both thresholds
// R4 - each input has its own settings and its own comparator
// R5 - upper limit 0 to 100, at least lower plus twice hysteresis
// R6 - lower limit at most upper minus twice hysteresis
// R7 - hysteresis at most half the band between the limits
// R8 - while flagged, a configured substitute level replaces the value
// R9 - substitute disabled passes the measured value unchanged
// R10 - an active hold keeps the held value ahead of the substitute
// R11 - limits ignore the frequency start and end scaling
// R12 - percent refers to 0..10 V or 4..20 mA per input mode
// R13 - software sets the upper limit at the open-circuit level
// R14 - software sets the lower limit at the short-circuit level
// R15 - open wiring drops input to minimum, raising flag and substitute
// R16 - shorted wiring lifts input to maximum, raising flag and substitute
// R17 - flag leaves only past the edge plus hysteresis, enters inside it
// R18 - flags and selected value update together on each sample
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
`include "wcmp_cfg.svh"

module wcmp_top (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// analog samples
	input wire logic [9:0] I_ANALOG_INPUT_ONE,
	input wire logic [9:0] I_ANALOG_INPUT_TWO,
	input wire logic I_SMP_VLD,
	input wire logic I_ANALOG_VALUE_HOLD,
	// selected values
	output wcmp_pkg::wcmp_pm_t O_VALUE_ONE,
	output wcmp_pkg::wcmp_pm_t O_VALUE_TWO,
	// flags
	output logic O_INPUT_ONE_WINDOW_FLAG,
	output logic O_INPUT_TWO_WINDOW_FLAG,
	output logic O_INPUT_ONE_OPEN_FLAG,
	output logic O_INPUT_TWO_OPEN_FLAG,
	// output terminals a, b, c
	output logic [2:0] O_TERM,
	// interrupt
	output logic O_IRQ
);
	import wcmp_pkg::*;

	function automatic logic route(input logic [7:0] code, input logic f1,
		input logic f2);
		logic r;
		r = 1'b0;
		unique case (code)
			`WCMP_FN_OPEN1, `WCMP_FN_WIN1: begin
				r = f1;
			end
			`WCMP_FN_OPEN2, `WCMP_FN_WIN2: begin
				r = f2;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		route = r;
	endfunction

	// registers
	logic [1:0] ctrl;
	wcmp_cfg_s cfg1;
	wcmp_cfg_s cfg2;
	wcmp_term_s term;
	logic [3:0] ists;
	logic [3:0] imsk;
	logic [2:0] term_q;
	logic flag1_q;
	logic flag2_q;

	// bus decode
	logic acc;
	logic wr;
	logic sel_ctrl;
	logic sel_cfg1;
	logic sel_cfg2;
	logic sel_term;
	logic sel_stat;
	logic sel_ists;
	logic sel_imsk;
	logic sel_val;
	logic hit;
	logic wr_cfg1;
	logic wr_cfg2;
	logic ok1;
	logic ok2;
	logic err;
	wcmp_cfg_s new_cfg;

	// channel results
	logic flag1;
	logic flag2;
	wcmp_pm_t val1;
	wcmp_pm_t val2;

	// events and next values
	logic [3:0] ev;
	logic [3:0] w1c;
	logic [3:0] next_ists;
	logic [2:0] next_term;

	assign acc = I_PSEL & I_PENABLE;
	assign wr = acc & I_PWRITE;

	assign sel_ctrl = (I_PADDR == `WCMP_A_CTRL);
	assign sel_cfg1 = (I_PADDR == `WCMP_A_CFG1);
	assign sel_cfg2 = (I_PADDR == `WCMP_A_CFG2);
	assign sel_term = (I_PADDR == `WCMP_A_TERM);
	assign sel_stat = (I_PADDR == `WCMP_A_STAT);
	assign sel_ists = (I_PADDR == `WCMP_A_ISTS);
	assign sel_imsk = (I_PADDR == `WCMP_A_IMSK);
	assign sel_val = (I_PADDR == `WCMP_A_VAL);
	assign hit = sel_ctrl | sel_cfg1 | sel_cfg2 | sel_term
		| sel_stat | sel_ists | sel_imsk | sel_val;

	// a setting outside its legal range is refused whole, old value kept
	assign new_cfg = wcmp_cfg_s'(I_PWDATA & `WCMP_CFG_MASK);
	assign ok1 = cfg_ok(new_cfg); // R5 R6 R7
	assign ok2 = cfg_ok(new_cfg); // R5 R6 R7
	assign wr_cfg1 = wr & sel_cfg1;
	assign wr_cfg2 = wr & sel_cfg2;
	assign err = !hit | (wr_cfg1 & !ok1) | (wr_cfg2 & !ok2);

	// zero wait states; error only qualifies the access phase
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = acc & err;

	assign O_PRDATA = !acc ? 32'h0000_0000 :
		sel_ctrl ? {30'h0, ctrl} :
		sel_cfg1 ? 32'(cfg1) :
		sel_cfg2 ? 32'(cfg2) :
		sel_term ? 32'(term) :
		sel_stat ? {28'h0, flag2, flag1, flag2, flag1} :
		sel_ists ? {28'h0, ists} :
		sel_imsk ? {28'h0, imsk} :
		sel_val ? {6'h0, val2, 6'h0, val1} :
		32'h0000_0000;

	// one comparator per input, each with its own settings
	wcmp_chan u_chan_one ( // R4
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_smp_vld(I_SMP_VLD),
		.i_raw(I_ANALOG_INPUT_ONE),
		.i_cur(ctrl[0]),
		.i_hold(I_ANALOG_VALUE_HOLD),
		.i_cfg(cfg1),
		.o_flag(flag1),
		.o_value(val1)
	);

	wcmp_chan u_chan_two ( // R4
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_smp_vld(I_SMP_VLD),
		.i_raw(I_ANALOG_INPUT_TWO),
		.i_cur(ctrl[1]),
		.i_hold(I_ANALOG_VALUE_HOLD),
		.i_cfg(cfg2),
		.o_flag(flag2),
		.o_value(val2)
	);

	// open and window flags share one comparator per input
	assign O_INPUT_ONE_WINDOW_FLAG = flag1;
	assign O_INPUT_TWO_WINDOW_FLAG = flag2;
	assign O_INPUT_ONE_OPEN_FLAG = flag1; // R15 R16
	assign O_INPUT_TWO_OPEN_FLAG = flag2; // R15 R16
	assign O_VALUE_ONE = val1;
	assign O_VALUE_TWO = val2;

	assign next_term[`WCMP_T_A] = route(term.output_terminal_a_select, flag1, flag2); // R1
	assign next_term[`WCMP_T_B] = route(term.output_terminal_b_select, flag1, flag2); // R1
	assign next_term[`WCMP_T_C] = route(term.output_terminal_c_select, flag1, flag2); // R1
	assign O_TERM = term_q;

	// events: rise and fall of each flag
	assign ev = {flag2_q & !flag2, flag1_q & !flag1, flag2 & !flag2_q, flag1 & !flag1_q};
	assign w1c = (wr & sel_ists) ? I_PWDATA[3:0] : 4'h0;
	// a new event beats a clear in the same cycle
	assign next_ists = (ists & ~w1c) | ev;
	assign O_IRQ = |(ists & imsk);

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl <= `WCMP_CTRL_RST;
			imsk <= `WCMP_IRQ_RST;
			term <= wcmp_term_s'(`WCMP_TERM_RST);
		end else if (wr) begin
			if (sel_ctrl)
				ctrl <= I_PWDATA[1:0];
			if (sel_imsk)
				imsk <= I_PWDATA[3:0];
			if (sel_term)
				term <= wcmp_term_s'(I_PWDATA & `WCMP_TERM_MASK);
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			cfg1 <= wcmp_cfg_s'(`WCMP_CFG_RST);
			cfg2 <= wcmp_cfg_s'(`WCMP_CFG_RST);
		end else begin
			if (wr_cfg1 && ok1)
				cfg1 <= new_cfg; // R5 R6 R7
			if (wr_cfg2 && ok2)
				cfg2 <= new_cfg; // R5 R6 R7
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ists <= `WCMP_IRQ_RST;
			flag1_q <= 1'b0;
			flag2_q <= 1'b0;
			term_q <= 3'h0;
		end else begin
			ists <= next_ists;
			flag1_q <= flag1;
			flag2_q <= flag2;
			term_q <= next_term; // R1
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	cfg_reject_a: assert property ( // R6
		wr_cfg1 && !ok1 |=> cfg1 == $past(cfg1))
		else $error("illegal limits were stored");
	cfg_band_a: assert property ( // R5
		{1'b0, cfg2.upper_limit} >= {1'b0, cfg2.lower_limit} + {3'h0, cfg2.hysteresis, 1'b0})
		else $error("stored band narrower than twice hysteresis");
	hys_range_a: assert property ( // R3
		cfg1.hysteresis <= `WCMP_HYS_MAX && cfg2.hysteresis <= `WCMP_HYS_MAX)
		else $error("hysteresis out of range");
	term_route_a: assert property ( // R1
		term.output_terminal_a_select == `WCMP_FN_WIN2 && $stable(term)
		|=> O_TERM[`WCMP_T_A] == $past(flag2))
		else $error("terminal a not following flag two");
	term_open_a: assert property ( // R1
		term.output_terminal_c_select == `WCMP_FN_OPEN1 && $stable(term)
		|=> O_TERM[`WCMP_T_C] == $past(flag1))
		else $error("terminal c not following flag one");
	irq_set_a: assert property (
		$rose(flag1) |=> ists[`WCMP_EV_RISE1] ##0 (O_IRQ || !imsk[`WCMP_EV_RISE1]))
		else $error("rise of flag one not latched");

	// every flag edge must leave a sticky trace, even when cleared at once
	irq_rise_two_a: assert property (
		$rose(flag2) |=> ists[`WCMP_EV_RISE2])
		else $error("rise of flag two not latched");
	irq_fall_one_a: assert property (
		$fell(flag1) |=> ists[`WCMP_EV_FALL1])
		else $error("fall of flag one not latched");
	irq_fall_two_a: assert property (
		$fell(flag2) |=> ists[`WCMP_EV_FALL2])
		else $error("fall of flag two not latched");
	ists_sticky_a: assert property (
		ists[`WCMP_EV_RISE1] && !(wr && sel_ists && I_PWDATA[`WCMP_EV_RISE1])
		|=> ists[`WCMP_EV_RISE1])
		else $error("status bit lost without clear");
	ists_clear_a: assert property (
		wr && sel_ists && I_PWDATA[`WCMP_EV_RISE1] && !ev[`WCMP_EV_RISE1]
		|=> !ists[`WCMP_EV_RISE1])
		else $error("status bit not cleared");

	// bus answers
	err_unmapped_a: assert property (
		acc && !hit |-> O_PSLVERR)
		else $error("unmapped access without error");
	rd_idle_a: assert property (
		!acc |-> O_PRDATA == 32'h0000_0000)
		else $error("read data outside access phase");
	ctrl_wr_a: assert property ( // R12
		wr && sel_ctrl |=> ctrl == $past(I_PWDATA[1:0]))
		else $error("mode write not stored");
	imsk_wr_a: assert property (
		wr && sel_imsk |=> imsk == $past(I_PWDATA[3:0]))
		else $error("mask write not stored");

	// stored settings stay inside their legal ranges, and legal writes are stored
	cfg_band_one_a: assert property ( // R7
		{1'b0, cfg1.upper_limit} >= {1'b0, cfg1.lower_limit} + {3'h0, cfg1.hysteresis, 1'b0})
		else $error("stored band one narrower than twice hysteresis");
	upper_range_a: assert property ( // R5
		cfg1.upper_limit <= `WCMP_PCT_MAX && cfg2.upper_limit <= `WCMP_PCT_MAX)
		else $error("upper limit above full scale");
	sub_range_a: assert property ( // R8
		cfg1.substitute_level <= `WCMP_PCT_MAX && cfg2.substitute_level <= `WCMP_PCT_MAX)
		else $error("substitute level above full scale");
	cfg_take_a: assert property ( // R3
		wr_cfg2 && ok2 |=> cfg2 == $past(new_cfg))
		else $error("legal settings not stored");

	// terminal routing
	term_b_a: assert property ( // R1
		term.output_terminal_b_select == `WCMP_FN_OPEN2 && $stable(term)
		|=> O_TERM[`WCMP_T_B] == $past(flag2))
		else $error("terminal b not following flag two");
	term_none_a: assert property ( // R1
		!(term.output_terminal_a_select inside {`WCMP_FN_OPEN1, `WCMP_FN_OPEN2,
		`WCMP_FN_WIN1, `WCMP_FN_WIN2}) && $stable(term) |=> !O_TERM[`WCMP_T_A])
		else $error("unassigned terminal a driven");

endmodule

`default_nettype wire

// ===== awc_src.sv
// awc_src.sv: model of the external analog source feeding both inputs
// assumes the bench clock; one strobe per sample pair
`default_nettype none

module awc_src (
	// clock
	input wire logic i_clk,
	// samples
	output logic [9:0] o_one,
	output logic [9:0] o_two,
	output logic o_vld
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_one = 10'h000;
		o_two = 10'h000;
		o_vld = 1'b0;
	end

	// lines are inverted after the strobe, so a stale sample never looks valid
	task automatic send(input logic [9:0] a, input logic [9:0] b, input int gap);
		repeat (gap) @(posedge i_clk);
		@(posedge i_clk);
		o_one <= a;
		o_two <= b;
		o_vld <= 1'b1;
		@(posedge i_clk);
		o_vld <= 1'b0;
		o_one <= ~a;
		o_two <= ~b;
	endtask
endmodule

`default_nettype wire

// ===== analog_window_comparator_tb.sv
// analog_window_comparator_tb.sv: self-checking bench of the window comparator
// assumes wcmp_pkg, wcmp_top and awc_src are compiled first
`default_nettype none

module analog_window_comparator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import wcmp_pkg::*;

	logic clk, rst, psel, pen, pwr, hold, vld, pready, pslverr, er;
	logic w1, w2, o1, o2, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] a1, a2;
	logic [2:0] term;
	wcmp_pm_t v1, v2;
	int bad_count, tests_run;

	awc_src awc_src_i (.i_clk(clk), .o_one(a1), .o_two(a2), .o_vld(vld));

	wcmp_top wcmp_top_i (
		.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_ANALOG_INPUT_ONE(a1), .I_ANALOG_INPUT_TWO(a2),
		.I_SMP_VLD(vld), .I_ANALOG_VALUE_HOLD(hold), .O_VALUE_ONE(v1), .O_VALUE_TWO(v2),
		.O_INPUT_ONE_WINDOW_FLAG(w1), .O_INPUT_TWO_WINDOW_FLAG(w2),
		.O_INPUT_ONE_OPEN_FLAG(o1), .O_INPUT_TWO_OPEN_FLAG(o2), .O_TERM(term), .O_IRQ(irq)
	);

	task automatic conclude;
		$display("mismatches %0d in %0d checks", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask

	// zero wait states are expected, but the wait stays bounded anyway
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("write error", {31'h0, er}, {31'h0, e});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask

	function automatic logic [31:0] cfg(input logic [6:0] u, input logic [6:0] l,
		input logic [3:0] h, input logic [6:0] s, input logic en);
		cfg = {en, s, 4'h0, h, 1'b0, l, 1'b0, u};
	endfunction

	// flags, term and irq have all landed two edges after the taken edge
	task automatic smp(input logic [9:0] a, input logic [9:0] b, input int gap);
		awc_src_i.send(a, b, gap);
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic out(input logic [1:0] f, input logic [9:0] e1, input logic [9:0] e2);
		chk("window flags", {30'h0, w2, w1}, {30'h0, f});
		chk("open flags", {30'h0, o2, o1}, {30'h0, f});
		chk("value one", {22'h0, v1}, {22'h0, e1});
		chk("value two", {22'h0, v2}, {22'h0, e2});
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		hold = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdc(8'h04, 32'h0000_0064, "cfg one reset");
		rdc(8'h0C, 32'h0000_0000, "term reset");
		rdc(8'h20, 32'h0000_0000, "unmapped read");
		chk("unmapped error", {31'h0, er}, 32'h1);
		wr(8'h04, cfg(7'h1E, 7'h14, 4'hA, 7'h00, 1'b0), 1'b1);
		wr(8'h04, cfg(7'h1E, 7'h14, 4'h6, 7'h00, 1'b0), 1'b1);
		wr(8'h04, cfg(7'h3C, 7'h33, 4'h5, 7'h00, 1'b0), 1'b1);
		wr(8'h04, cfg(7'h64, 7'h00, 4'hB, 7'h00, 1'b0), 1'b1);
		rdc(8'h04, 32'h0000_0064, "cfg one kept");
		wr(8'h04, cfg(7'h3C, 7'h14, 4'h5, 7'h32, 1'b1), 1'b0);
		wr(8'h0C, 32'h0036_1C1B, 1'b0);
		wr(8'h18, 32'h0000_0001, 1'b0);
		smp(10'h12C, 10'h190, 0);
		out(2'h3, 10'h1F4, 10'h190);
		chk("terminals", {29'h0, term}, 32'h7);
		chk("irq raised", {31'h0, irq}, 32'h1);
		wr(8'h14, 32'h0000_0001, 1'b0);
		@(negedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		// slow source: the sample arrives after idle cycles
		smp(10'h0C8, 10'h000, 3);
		out(2'h3, 10'h1F4, 10'h000);
		smp(10'h064, 10'h000, 0);
		out(2'h2, 10'h064, 10'h000);
		@(posedge clk);
		hold <= 1'b1;
		smp(10'h12C, 10'h000, 0);
		out(2'h3, 10'h064, 10'h000);
		@(posedge clk);
		hold <= 1'b0;
		smp(10'h294, 10'h000, 0);
		out(2'h2, 10'h294, 10'h000);
		wr(8'h08, cfg(7'h0A, 7'h00, 4'h0, 7'h4B, 1'b1), 1'b0);
		smp(10'h294, 10'h000, 0);
		out(2'h2, 10'h294, 10'h2EE);
		wr(8'h08, cfg(7'h64, 7'h5A, 4'h0, 7'h19, 1'b1), 1'b0);
		wr(8'h0C, 32'h001C_0037, 1'b0);
		smp(10'h294, 10'h3E8, 0);
		out(2'h2, 10'h294, 10'h0FA);
		chk("terminals", {29'h0, term}, 32'h5);
		wr(8'h00, 32'h0000_0002, 1'b0);
		wr(8'h08, cfg(7'h64, 7'h00, 4'h0, 7'h00, 1'b0), 1'b0);
		smp(10'h294, 10'h258, 0);
		out(2'h2, 10'h294, 10'h1F4);
		smp(10'h294, 10'h064, 0);
		out(2'h2, 10'h294, 10'h000);
		rdc(8'h10, 32'h0000_000A, "status");
		conclude();
	end
endmodule

`default_nettype wire
